// ==== dswi_pkg.sv ====
package dswi_pkg;

  // Clock and time bases.
  localparam int CLK_HZ          = 200_000_000;
  localparam int TICK_TIME_MS    = 1;
  localparam int TICK_CYCLES     = CLK_HZ / 1000 * TICK_TIME_MS;
  localparam int RATE_TOP_BAUD   = 9600;
  localparam int RATE_TOP_CYCLES = CLK_HZ / RATE_TOP_BAUD;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_REF      = 8'h04;
  localparam logic [7:0] OFS_STATUS   = 8'h08;
  localparam logic [7:0] OFS_FREQ     = 8'h0C;
  localparam logic [7:0] OFS_COMM     = 8'h10;
  localparam logic [7:0] OFS_SRC      = 8'h14;
  localparam logic [7:0] OFS_REFSPAN  = 8'h18;
  localparam logic [7:0] OFS_FREQSPAN = 8'h1C;
  localparam logic [7:0] OFS_ILIM     = 8'h20;

  // Status word bit positions.
  localparam int ST_RUN    = 11;
  localparam int ST_NOFUNC = 12;
  localparam int ST_VOLT   = 13;
  localparam int ST_ILIM   = 14;
  localparam int ST_THERM  = 15;

  // Control word bit positions.
  localparam int CW_PRESET  = 0;
  localparam int CW_BRAKE   = 2;
  localparam int CW_COAST   = 3;
  localparam int CW_START   = 6;
  localparam int CW_RESET   = 7;
  localparam int CW_VALID   = 10;
  localparam int CW_SETUP   = 13;
  localparam int CW_REVERSE = 15;

  // Field positions in the communication and source registers.
  localparam int COMM_PROTO = 0;
  localparam int COMM_ADDR  = 8;
  localparam int COMM_BAUD  = 16;
  localparam int SRC_COAST  = 0;
  localparam int SRC_BRAKE  = 2;
  localparam int SRC_START  = 4;
  localparam int SRC_REV    = 6;
  localparam int SRC_SETUP  = 8;
  localparam int SRC_PRESET = 10;

  // Reference scaling.
  localparam int REF_SHIFT = 14;
  localparam logic signed [33:0] REF_LIMIT = 34'sh00007FFF;

  typedef enum logic [1:0] {
    PROTO_NATIVE = 2'h0, PROTO_SECOND = 2'h1, PROTO_THIRD = 2'h2, PROTO_MODBUS = 2'h3
  } dswi_proto_e;

  typedef enum logic [1:0] {
    SRC_DIGITAL = 2'h0, SRC_SERIAL = 2'h1, SRC_AND = 2'h2, SRC_OR = 2'h3
  } dswi_src_e;

  typedef enum logic [2:0] {
    BAUD_300 = 3'h0, BAUD_600 = 3'h1, BAUD_1200 = 3'h2,
    BAUD_2400 = 3'h3, BAUD_4800 = 3'h4, BAUD_9600 = 3'h5
  } dswi_baud_e;

  // Values after reset.
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [7:0]  ADDR_RST  = 8'h01;
  localparam logic [11:0] SRC_RST   = 12'hF3F;
  localparam logic [31:0] SPAN_RST  = 32'h0000_0000;
  localparam logic [31:0] ILIM_RST  = 32'h0000_FFFF;

  // Commands, whether from terminals or after gating.
  typedef struct packed {
    logic       coast;
    logic       brake;
    logic       start;
    logic       reverse;
    logic [1:0] setup;
    logic [1:0] preset;
  } dswi_cmd_s;

  // Measurements from the motor control logic on the same clock.
  typedef struct packed {
    logic        dcFault;
    logic [15:0] current;
    logic        motorHot;
    logic        driveHot;
    logic        thermistorHot;
    logic [15:0] outFreq;
    logic        outReverse;
  } dswi_meas_s;

  // Local control panel settings port.
  typedef struct packed {
    logic       setAddr;
    logic [7:0] addr;
    logic       setBaud;
    logic [2:0] baud;
  } dswi_panel_s;

endpackage

// ==== dswi_word_if.sv ====
`timescale 1ns/1ps
module dswi_word_if
  import dswi_pkg::*;
#(
  parameter int TICK_LEN  = TICK_CYCLES,
  parameter int RATE_BASE = RATE_TOP_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire dswi_cmd_s   termIn,
  input  wire dswi_meas_s  meas,
  input  wire dswi_panel_s panel,
  output dswi_cmd_s        cmd,
  output logic      [15:0] statusWord,
  output logic      [15:0] outFreqWord,
  output logic      [15:0] refCmd,
  output logic             refReverse,
  output logic             tripped,
  output logic             baudTick,
  output logic      [1:0]  protocol,
  output logic      [7:0]  stationAddr,
  output logic      [2:0]  baudCode
);

  function automatic logic gateBit(input logic [1:0] src, input logic term, input logic ser);
    unique case (src)
      SRC_DIGITAL: gateBit = term;
      SRC_SERIAL:  gateBit = ser;
      SRC_AND:     gateBit = term & ser;
      default:     gateBit = term | ser;
    endcase
  endfunction

  function automatic logic addrOk(input logic [1:0] p, input logic [7:0] a);
    unique case (p)
      PROTO_NATIVE: addrOk = (a <= 8'h7E);
      PROTO_SECOND: addrOk = (a >= 8'h01);
      PROTO_THIRD:  addrOk = (a <= 8'h62);
      default:      addrOk = (a >= 8'h01) && (a <= 8'hF7);
    endcase
  endfunction

  function automatic logic baudOk(input logic [1:0] p, input logic [2:0] b);
    unique case (p)
      PROTO_NATIVE: baudOk = (b <= BAUD_9600);
      PROTO_SECOND: baudOk = (b == BAUD_9600);
      PROTO_THIRD:  baudOk = (b == BAUD_4800) || (b == BAUD_9600);
      default:      baudOk = (b <= BAUD_9600);
    endcase
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      mergeBytes[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // Terminal levels come from pins and pass two flip-flops before use.
  dswi_cmd_s   termMeta;
  dswi_cmd_s   termS;
  logic [15:0] serialCtrl;
  logic [15:0] serialRef;
  logic [11:0] srcSel;
  logic [31:0] refSpan;
  logic [31:0] freqSpan;
  logic [31:0] ilimCfg;
  logic [31:0] tickCount;
  logic [15:0] tripCount;
  logic [31:0] rateCount;
  logic        resetBitLast;
  logic        wbWrite;
  logic        wbRead;
  logic [31:0] wdataMerged;
  logic [31:0] commView;
  logic        overCurrent;
  dswi_cmd_s   next_cmd;
  logic [31:0] next_rdata;
  logic [31:0] rateLimit;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      termMeta <= '0;
      termS    <= '0;
    end else begin
      termMeta <= termIn;
      termS    <= termMeta;
    end
  end

  // Wishbone classic slave; one wait state, ack drops the cycle after.
  assign wbWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign wbRead  = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign commView = {13'h0, baudCode, stationAddr, 6'h0, protocol};

  always_comb begin
    wdataMerged = 32'h0;
    unique case (wb_adr_i)
      OFS_CTRL:     wdataMerged = mergeBytes({16'h0, serialCtrl}, wb_dat_i, wb_sel_i);
      OFS_REF:      wdataMerged = mergeBytes({16'h0, serialRef}, wb_dat_i, wb_sel_i);
      OFS_COMM:     wdataMerged = mergeBytes(commView, wb_dat_i, wb_sel_i);
      OFS_SRC:      wdataMerged = mergeBytes({20'h0, srcSel}, wb_dat_i, wb_sel_i);
      OFS_REFSPAN:  wdataMerged = mergeBytes(refSpan, wb_dat_i, wb_sel_i);
      OFS_FREQSPAN: wdataMerged = mergeBytes(freqSpan, wb_dat_i, wb_sel_i);
      OFS_ILIM:     wdataMerged = mergeBytes(ilimCfg, wb_dat_i, wb_sel_i);
      default:      wdataMerged = 32'h0;
    endcase
  end

  always_comb begin
    unique case (wb_adr_i)
      OFS_CTRL:     next_rdata = {16'h0, serialCtrl};
      OFS_REF:      next_rdata = {16'h0, serialRef};
      OFS_STATUS:   next_rdata = {16'h0, statusWord};
      OFS_FREQ:     next_rdata = {16'h0, outFreqWord};
      OFS_COMM:     next_rdata = commView;
      OFS_SRC:      next_rdata = {20'h0, srcSel};
      OFS_REFSPAN:  next_rdata = refSpan;
      OFS_FREQSPAN: next_rdata = freqSpan;
      OFS_ILIM:     next_rdata = ilimCfg;
      default:      next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wbWrite || wbRead;
      wb_dat_o <= wbRead ? next_rdata : 32'h0;
    end
  end

  // A control word only takes effect when its data-valid bit is set.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      serialCtrl <= CTRL_RST;
      serialRef  <= 16'h0;
      srcSel     <= SRC_RST;
      refSpan    <= SPAN_RST;
      freqSpan   <= SPAN_RST;
      ilimCfg    <= ILIM_RST;
    end else if (wbWrite) begin
      if (wb_adr_i == OFS_CTRL && wdataMerged[CW_VALID]) serialCtrl <= wdataMerged[15:0];
      if (wb_adr_i == OFS_REF) serialRef <= wdataMerged[15:0];
      if (wb_adr_i == OFS_SRC) srcSel <= wdataMerged[11:0];
      if (wb_adr_i == OFS_REFSPAN) refSpan <= wdataMerged;
      if (wb_adr_i == OFS_FREQSPAN) freqSpan <= wdataMerged;
      if (wb_adr_i == OFS_ILIM) ilimCfg <= wdataMerged;
    end
  end

  // Protocol writes are refused when they would strand the address or rate, or race a panel write.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      protocol <= PROTO_NATIVE;
    end else if (wbWrite && wb_adr_i == OFS_COMM) begin
      if (!panel.setAddr && !panel.setBaud && addrOk(wdataMerged[COMM_PROTO +: 2], stationAddr) &&
          baudOk(wdataMerged[COMM_PROTO +: 2], baudCode)) begin
        protocol <= wdataMerged[COMM_PROTO +: 2];
      end
    end
  end

  // Address and rate come only from the panel; bus writes to those fields are dropped.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stationAddr <= ADDR_RST;
      baudCode    <= BAUD_9600;
    end else begin
      if (panel.setAddr && addrOk(protocol, panel.addr)) begin
        stationAddr <= panel.addr;
      end
      if (panel.setBaud && baudOk(protocol, panel.baud)) begin
        baudCode <= panel.baud;
      end
    end
  end

  // Bit rate enable: the base count is for 9600 baud, slower codes double it per step.
  assign rateLimit = RATE_BASE[31:0] << (3'(BAUD_9600) - baudCode);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rateCount <= 32'h0;
      baudTick  <= 1'b0;
    end else if (rateCount >= rateLimit - 32'h1) begin
      rateCount <= 32'h0;
      baudTick  <= 1'b1;
    end else begin
      rateCount <= rateCount + 32'h1;
      baudTick  <= 1'b0;
    end
  end

  // Coasting and braking are active low on both sources, so they are inverted before gating.
  always_comb begin
    next_cmd.coast   = gateBit(srcSel[SRC_COAST +: 2], !termS.coast, !serialCtrl[CW_COAST]);
    next_cmd.brake   = gateBit(srcSel[SRC_BRAKE +: 2], !termS.brake, !serialCtrl[CW_BRAKE]);
    next_cmd.start   = gateBit(srcSel[SRC_START +: 2], termS.start, serialCtrl[CW_START]);
    next_cmd.reverse = gateBit(srcSel[SRC_REV +: 2], termS.reverse, serialCtrl[CW_REVERSE]);
    for (int i = 0; i < 2; i++) begin
      next_cmd.setup[i]  = gateBit(srcSel[SRC_SETUP +: 2], termS.setup[i], serialCtrl[CW_SETUP + i]);
      next_cmd.preset[i] = gateBit(srcSel[SRC_PRESET +: 2], termS.preset[i], serialCtrl[CW_PRESET + i]);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cmd <= '0;
    end else begin
      cmd <= next_cmd;
    end
  end

  assign overCurrent = meas.current > ilimCfg[15:0];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      statusWord <= 16'h0;
    end else begin
      statusWord[10:0]      <= 11'h0;
      statusWord[ST_RUN]    <= cmd.start || (meas.outFreq != 16'h0);
      statusWord[ST_NOFUNC] <= 1'b0;
      statusWord[ST_VOLT]   <= meas.dcFault;
      statusWord[ST_ILIM]   <= overCurrent;
      statusWord[ST_THERM]  <= meas.motorHot || meas.driveHot || meas.thermistorHot;
    end
  end

  // Trip delay counts millisecond ticks; a rising reset bit clears the trip unless it sets again.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tickCount    <= 32'h0;
      tripCount    <= 16'h0;
      tripped      <= 1'b0;
      resetBitLast <= 1'b0;
    end else begin
      resetBitLast <= serialCtrl[CW_RESET];
      tickCount    <= (tickCount >= TICK_LEN[31:0] - 32'h1) ? 32'h0 : tickCount + 32'h1;
      if (!statusWord[ST_ILIM]) begin
        tripCount <= 16'h0;
      end else if (tickCount == 32'h0 && tripCount != 16'hFFFF) begin
        tripCount <= tripCount + 16'h1;
      end
      if (statusWord[ST_ILIM] && tripCount >= ilimCfg[31:16]) begin
        tripped <= 1'b1;
      end else if (serialCtrl[CW_RESET] && !resetBitLast) begin
        tripped <= 1'b0;
      end
    end
  end

  // Reference scaling: magnitude is mapped onto the span, sign gives direction.
  logic signed [33:0] refMag;
  logic signed [33:0] refScaled;
  logic signed [33:0] refSpanDiff;

  always_comb begin
    refMag      = serialRef[15] ? -34'(signed'(serialRef)) : 34'(signed'(serialRef));
    refSpanDiff = 34'(refSpan[31:16]) - 34'(refSpan[15:0]);
    refScaled   = signed'(34'(refSpan[15:0])) + ((refSpanDiff * refMag) >>> REF_SHIFT);
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      refCmd     <= 16'h0;
      refReverse <= 1'b0;
    end else begin
      refReverse <= serialRef[15];
      if (refScaled < 34'sh0) begin
        refCmd <= 16'h0;
      end else if (refScaled > 34'sh0000FFFF) begin
        refCmd <= 16'hFFFF;
      end else begin
        refCmd <= refScaled[15:0];
      end
    end
  end

  // Frequency encoding uses a divider; it is combinational and sets the critical path here.
  logic signed [33:0] freqNum;
  logic signed [33:0] freqDen;
  logic signed [33:0] freqQuot;
  logic signed [33:0] freqSat;

  always_comb begin
    freqNum  = (34'(meas.outFreq) - 34'(freqSpan[15:0])) <<< REF_SHIFT;
    freqDen  = 34'(freqSpan[31:16]) - 34'(freqSpan[15:0]);
    freqQuot = (freqDen <= 34'sh0) ? 34'sh0 : freqNum / freqDen;
    if (freqQuot > REF_LIMIT) begin
      freqSat = REF_LIMIT;
    end else if (freqQuot < 34'sh0) begin
      freqSat = 34'sh0;
    end else begin
      freqSat = freqQuot;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      outFreqWord <= 16'h0;
    end else begin
      outFreqWord <= meas.outReverse ? 16'(-freqSat) : freqSat[15:0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_run;
    ##1 statusWord[ST_RUN] == ($past(cmd.start) || ($past(meas.outFreq) != 16'h0));
  endproperty
  a_run: assert property (p_run) else $error("Running bit wrong.");
  property p_nofunc;
    statusWord[ST_NOFUNC] == 1'b0;
  endproperty
  a_nofunc: assert property (p_nofunc) else $error("Bit 12 not zero.");
  property p_volt;
    $rose(meas.dcFault) |=> statusWord[ST_VOLT];
  endproperty
  a_volt: assert property (p_volt) else $error("Voltage warning missed.");
  property p_trip;
    $rose(tripped) |-> $past(statusWord[ST_ILIM]) && ($past(tripCount) >= $past(ilimCfg[31:16]));
  endproperty
  a_trip: assert property (p_trip) else $error("Trip without expired overcurrent.");
  property p_therm;
    (meas.motorHot || meas.thermistorHot) |=> statusWord[ST_THERM];
  endproperty
  a_therm: assert property (p_therm) else $error("Thermal warning missed.");
  property p_refzero;
    (serialRef == 16'h0) ##1 $stable(refSpan) |-> refCmd == refSpan[15:0];
  endproperty
  a_refzero: assert property (p_refzero) else $error("Zero reference not at minimum.");
  property p_refdir;
    ##1 refReverse == $past(serialRef[15]);
  endproperty
  a_refdir: assert property (p_refdir) else $error("Direction not from reference sign.");
  property p_freqlow;
    (meas.outFreq == freqSpan[15:0]) |=> outFreqWord == 16'h0;
  endproperty
  a_freqlow: assert property (p_freqlow) else $error("Low limit not encoded as zero.");
  property p_addrlock;
    (wbWrite && !panel.setAddr) |=> $stable(stationAddr);
  endproperty
  a_addrlock: assert property (p_addrlock) else $error("Address changed from bus.");
  property p_baudlock;
    (wbWrite && !panel.setBaud) |=> $stable(baudCode);
  endproperty
  a_baudlock: assert property (p_baudlock) else $error("Bit rate changed from bus.");
  property p_cfgok;
    addrOk(protocol, stationAddr) && baudOk(protocol, baudCode);
  endproperty
  a_cfgok: assert property (p_cfgok) else $error("Address or rate illegal for protocol.");
  property p_serial;
    (srcSel[SRC_START +: 2] == SRC_SERIAL) |=> cmd.start == $past(serialCtrl[CW_START]);
  endproperty
  a_serial: assert property (p_serial) else $error("Serial source ignored.");
  property p_and;
    (srcSel[SRC_START +: 2] == SRC_AND && !termS.start) |=> !cmd.start;
  endproperty
  a_and: assert property (p_and) else $error("AND source started alone.");
  property p_or;
    (srcSel[SRC_START +: 2] == SRC_OR && termS.start) |=> cmd.start;
  endproperty
  a_or: assert property (p_or) else $error("OR source missed terminal.");
  property p_coast;
    (srcSel[SRC_COAST +: 2] == SRC_DIGITAL && !termS.coast) |=> cmd.coast;
  endproperty
  a_coast: assert property (p_coast) else $error("Low coast terminal ignored.");
endmodule // dswi_word_if

// ==== dswi_master_model.sv ====
`timescale 1ns/1ps
// Serial network master seen through the register bus; it never releases a request before ack.
module dswi_master_model (
  input  wire logic        clk_sys,
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  output logic             wb_we_i,
  output logic      [7:0]  wb_adr_i,
  output logic      [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_i,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_o
);
  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
  end

  // Released address, data and write-enable lines show the inverse of the last value, so a slave that samples them late is caught.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                      output logic [31:0] rdat, output logic ok);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wdat;
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    ok = (wb_ack_o === 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= ~we;
    wb_adr_i <= ~adr;
    wb_dat_i <= ~wdat;
    @(posedge clk_sys);
  endtask

  // The reference is a signed word; reversing is the two's complement of the magnitude.
  function automatic logic [31:0] refWord(input logic signed [15:0] magnitude, input logic reverse);
    refWord = {16'h0000, reverse ? -magnitude : magnitude};
  endfunction
endmodule // dswi_master_model

// ==== drive_serial_word_interface_tb.sv ====
`timescale 1ns/1ps
module drive_serial_word_interface_tb
  import dswi_pkg::*;
;
  logic clk_sys, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, refReverse, tripped, baudTick;
  logic [7:0] wb_adr_i, stationAddr;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] statusWord, outFreqWord, refCmd;
  logic [1:0] protocol;
  logic [2:0] baudCode;
  dswi_cmd_s termIn, cmd;
  dswi_meas_s meas;
  dswi_panel_s panel;
  int badCount = 0;
  int checksDone = 0;

  dswi_word_if #(.TICK_LEN(8), .RATE_BASE(4)) dswi_word_if_inst (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .termIn(termIn), .meas(meas), .panel(panel), .cmd(cmd),
    .statusWord(statusWord), .outFreqWord(outFreqWord), .refCmd(refCmd), .refReverse(refReverse),
    .tripped(tripped), .baudTick(baudTick), .protocol(protocol), .stationAddr(stationAddr),
    .baudCode(baudCode));

  dswi_master_model dswi_master_model_inst (
    .clk_sys(clk_sys), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o));

  always #2.5 clk_sys = ~clk_sys;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checksDone++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", checksDone, badCount);
    if (badCount == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] r;
    logic ok;
    dswi_master_model_inst.xfer(1'b1, adr, d, r, ok);
    check({31'h0, ok}, 32'h1, "write ack");
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
    logic [31:0] r;
    logic ok;
    dswi_master_model_inst.xfer(1'b0, adr, 32'h0000_0000, r, ok);
    check({31'h0, ok}, 32'h1, "read ack");
    check(r, exp, what);
  endtask

  task automatic tReset();
    rd(OFS_COMM, 32'h0005_0100, "comm after reset");
    rd(OFS_SRC, 32'h0000_0F3F, "source selectors after reset");
    wr(8'h40, 32'hFFFF_FFFF);
    rd(8'h40, 32'h0000_0000, "unmapped read");
    check({16'h0, statusWord}, 32'h0, "status after reset");
    $display("test reset done");
  endtask

  task automatic tStatus();
    wr(OFS_ILIM, 32'h0002_0100);
    @(posedge clk_sys);
    meas.dcFault <= 1'b1;
    meas.current <= 16'h0200;
    settle(3);
    check({16'h0, statusWord}, 32'h6000, "voltage and current bits");
    rd(OFS_STATUS, 32'h0000_6000, "status read");
    check({31'h0, tripped}, 32'h0, "no trip before delay");
    settle(40);
    check({31'h0, tripped}, 32'h1, "trip after delay");
    @(posedge clk_sys);
    meas <= '0;
    wr(OFS_CTRL, 32'h0000_0488);
    wr(OFS_CTRL, 32'h0000_0408);
    settle(2);
    check({31'h0, tripped}, 32'h0, "trip cleared");
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      meas.motorHot <= (i == 0);
      meas.driveHot <= (i == 1);
      meas.thermistorHot <= (i == 2);
      settle(3);
      check({16'h0, statusWord}, 32'h8000, "thermal bit");
    end
    @(posedge clk_sys);
    meas.thermistorHot <= 1'b0;
    meas.outFreq <= 16'h0001;
    settle(3);
    check({16'h0, statusWord}, 32'h0800, "running on frequency");
    @(posedge clk_sys);
    meas <= '0;
    settle(3);
    check({16'h0, statusWord}, 32'h0000, "not running");
    $display("test status done");
  endtask

  task automatic tRef();
    wr(OFS_REFSPAN, 32'h4100_0100);
    wr(OFS_REF, dswi_master_model_inst.refWord(16'sh2000, 1'b0));
    settle(3);
    check({15'h0, refReverse, refCmd}, 32'h0000_2100, "half reference");
    wr(OFS_REF, dswi_master_model_inst.refWord(16'sh2000, 1'b1));
    settle(3);
    check({15'h0, refReverse, refCmd}, 32'h0001_2100, "reversed reference");
    wr(OFS_REF, 32'h0000_4000);
    settle(3);
    check({15'h0, refReverse, refCmd}, 32'h0000_4100, "full reference");
    $display("test reference done");
  endtask

  task automatic tFreq();
    wr(OFS_FREQSPAN, 32'h0032_0000);
    @(posedge clk_sys);
    meas.outFreq <= 16'h0019;
    settle(3);
    check({16'h0, outFreqWord}, 32'h0000_2000, "half frequency");
    @(posedge clk_sys);
    meas.outReverse <= 1'b1;
    settle(3);
    rd(OFS_FREQ, 32'h0000_E000, "reverse frequency read");
    @(posedge clk_sys);
    meas <= '0;
    $display("test frequency done");
  endtask

  // Kind 0 sets the address from the panel, kind 1 the bit rate, kind 2 writes the protocol over the bus.
  task automatic step(input int kind, input logic [7:0] v, input logic [12:0] exp);
    if (kind == 2) wr(OFS_COMM, {30'h0, v[1:0]});
    else begin
      @(posedge clk_sys);
      panel.setAddr <= (kind == 0);
      panel.setBaud <= (kind == 1);
      panel.addr <= v;
      panel.baud <= v[2:0];
      @(posedge clk_sys);
      panel <= '0;
    end
    settle(2);
    check({19'h0, protocol, stationAddr, baudCode}, {19'h0, exp}, "comm config");
  endtask

  task automatic measure(output int p);
    int n;
    n = 0;
    p = 1;
    while (baudTick !== 1'b1 && n < 400) begin
      settle(1);
      n++;
    end
    settle(1);
    while (baudTick !== 1'b1 && p < 400) begin
      settle(1);
      p++;
    end
  endtask

  task automatic tComm();
    int p;
    wr(OFS_COMM, 32'h0002_4003);
    settle(1);
    check({19'h0, protocol, stationAddr, baudCode}, {19'h0, 2'h3, 8'h01, 3'h5}, "bus fields");
    for (int c = 0; c < 4; c++) step(2, 8'(c), {2'(c), 8'h01, 3'h5});
    step(2, 8'h00, {2'h0, 8'h01, 3'h5});
    step(0, 8'h7E, {2'h0, 8'h7E, 3'h5});
    step(0, 8'h7F, {2'h0, 8'h7E, 3'h5});
    step(2, 8'h02, {2'h0, 8'h7E, 3'h5});
    step(0, 8'h00, {2'h0, 8'h00, 3'h5});
    step(2, 8'h01, {2'h0, 8'h00, 3'h5});
    step(2, 8'h03, {2'h0, 8'h00, 3'h5});
    step(0, 8'h62, {2'h0, 8'h62, 3'h5});
    step(2, 8'h02, {2'h2, 8'h62, 3'h5});
    step(1, 8'h03, {2'h2, 8'h62, 3'h5});
    step(1, 8'h04, {2'h2, 8'h62, 3'h4});
    step(2, 8'h01, {2'h2, 8'h62, 3'h4});
    step(2, 8'h00, {2'h0, 8'h62, 3'h4});
    for (int c = 0; c < 6; c++) begin
      step(1, 8'(c), {2'h0, 8'h62, 3'(c)});
      measure(p);
      measure(p);
      check(32'(p), 32'(4 << (5 - c)), "bit period");
    end
    $display("test communication done");
  endtask

  function automatic logic gate(input logic [1:0] c, input logic t, input logic s);
    case (c)
      2'h0: gate = t;
      2'h1: gate = s;
      2'h2: gate = t & s;
      default: gate = t | s;
    endcase
  endfunction

  task automatic tGate();
    logic t;
    logic s;
    logic g;
    logic gn;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SRC, {20'h0, {6{2'(c)}}});
      for (int i = 0; i < 4; i++) begin
        t = i[1];
        s = i[0];
        g = gate(2'(c), t, s);
        gn = gate(2'(c), !t, !s);
        @(posedge clk_sys);
        termIn <= {8{t}};
        wr(OFS_CTRL, {16'h0, 16'h0400 | ({16{s}} & 16'hE04F)});
        settle(4);
        check({24'h0, cmd}, {24'h0, gn, gn, {6{g}}}, "gated commands");
        check({31'h0, statusWord[ST_RUN]}, {31'h0, g}, "running on start");
      end
    end
    $display("test gating done");
  endtask

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    termIn = 8'hC0;
    meas = '0;
    panel = '0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    tReset();
    tStatus();
    tRef();
    tFreq();
    tComm();
    tGate();
    tallyAndFinish();
  end

  initial begin
    #300000;
    badCount++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    tallyAndFinish();
  end
endmodule // drive_serial_word_interface_tb
